// [verilog/dmc_ctrl.v]
// Host controller driving a 262144 x 9 asynchronous DRAM module.
`timescale 1ns/1ps
`include "dmc_defines.vh"
module dmc_ctrl #(
    parameter PWRUP_CYC = `DMC_PWRUP_CYC,
    parameter REF_CYC   = `DMC_REF_EVERY_CYC
) (
    // Clock and reset.
    input  wire        i_clk,
    input  wire        i_nrst,
    // User request port.
    input  wire        i_req,
    input  wire        i_we,
    input  wire [17:0] i_addr,
    input  wire [8:0]  i_wdata,
    output reg         o_busy,
    output reg         o_rvalid,
    output reg  [8:0]  o_rdata,
    output reg         o_ready,
    output reg         o_present,
    // DRAM module pins.
    output reg  [8:0]  o_addr,
    output reg         o_row_strobe_n,
    output reg         o_col_strobe_n,
    output reg         o_parity_col_strobe_n,
    output reg         o_write_enable_n,
    input  wire [7:0]  i_data_io,
    output reg  [7:0]  o_data_io,
    output reg         o_data_io_oe,
    output reg         o_parity_data_in,
    input  wire        i_parity_data_out,
    input  wire        i_presence_detect_n
);
    localparam S_PWRUP = 4'h0;
    localparam S_INIT  = 4'h1;
    localparam S_IDLE  = 4'h2;
    localparam S_ROW   = 4'h3;
    localparam S_COL   = 4'h4;
    localparam S_CASLO = 4'h5;
    localparam S_PRE   = 4'h6;
    localparam S_RFCAS = 4'h7;
    localparam S_RFRAS = 4'h8;
    localparam S_RFPRE = 4'h9;

    reg [3:0]  state_r;
    reg [3:0]  state_nxt;
    reg [15:0] cnt_r;
    reg [15:0] cnt_nxt;
    reg [15:0] ref_cnt_r;
    reg        ref_due_r;
    reg [3:0]  init_cnt_r;
    reg        we_r;
    reg [17:0] addr_r;
    reg [8:0]  wdata_r;
    wire [8:0] rd_sync;
    wire       prd_sync;
    wire       ref_set;

    // Timing loads, kept 32 bits wide here and sliced to the counter width where used.
    localparam [31:0] T_CSR = `DMC_TCSR_CYC;
    localparam [31:0] T_RCD = `DMC_TRCD_CYC + `DMC_TSYNC_CYC;
    localparam [31:0] T_CAS = `DMC_TCAS_CYC + `DMC_TSYNC_CYC;
    localparam [31:0] T_RAS = `DMC_TRAS_CYC;
    localparam [31:0] T_RP  = `DMC_TRP_CYC;

    // A refresh falls due at this edge; ready is withheld then so no request is dropped.
    assign ref_set = (ref_cnt_r >= REF_CYC[15:0] - 16'h0001);

    // Read pins cross two flops; they change asynchronously to our clock.
    dmc_sync #(.W(10)) u_sync (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .i_async ({i_presence_detect_n, i_parity_data_out, i_data_io}),
        .o_sync  ({prd_sync, rd_sync})
    );

    // Saturating down-count helper used by every timed state.
    function [15:0] dmc_dec;
        input [15:0] v;
        begin
            dmc_dec = (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
        end
    endfunction

    // Refresh interval timer: one internal refresh every 15 us covers 256 rows in 4 ms.
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            ref_cnt_r <= 16'h0000;
            ref_due_r <= 1'b0;
        end else if (ref_set) begin
            ref_cnt_r <= 16'h0000;
            ref_due_r <= 1'b1;
        end else begin
            ref_cnt_r <= ref_cnt_r + 16'h0001;
            if (state_r == S_RFCAS) begin
                ref_due_r <= 1'b0;
            end
        end
    end

    // Next-state logic; refresh has priority over a pending access.
    always @* begin
        state_nxt = state_r;
        cnt_nxt   = dmc_dec(cnt_r);
        case (state_r)
            S_PWRUP: begin
                if (cnt_r == 16'h0000) begin
                    state_nxt = S_RFCAS;
                    cnt_nxt   = T_CSR[15:0];
                end
            end
            S_IDLE: begin
                if (ref_due_r) begin
                    state_nxt = S_RFCAS;
                    cnt_nxt   = T_CSR[15:0];
                end else if (i_req && o_ready) begin
                    state_nxt = S_ROW;
                    cnt_nxt   = T_RCD[15:0];
                end
            end
            S_ROW: begin
                if (cnt_r == 16'h0000) begin
                    state_nxt = S_COL;
                    cnt_nxt   = 16'h0000;
                end
            end
            S_COL: begin
                state_nxt = S_CASLO;
                cnt_nxt   = T_CAS[15:0];
            end
            S_CASLO: begin
                if (cnt_r == 16'h0000) begin
                    state_nxt = S_PRE;
                    cnt_nxt   = T_RP[15:0];
                end
            end
            S_PRE, S_RFPRE: begin
                if (cnt_r == 16'h0000) begin
                    // Refresh waits for precharge, so read data is always taken first.
                    state_nxt = (init_cnt_r < `DMC_INIT_CYCLES) ? S_RFCAS : S_IDLE;
                    cnt_nxt   = T_CSR[15:0];
                end
            end
            S_RFCAS: begin
                if (cnt_r == 16'h0000) begin
                    state_nxt = S_RFRAS;
                    cnt_nxt   = T_RAS[15:0];
                end
            end
            S_RFRAS: begin
                if (cnt_r == 16'h0000) begin
                    state_nxt = S_RFPRE;
                    cnt_nxt   = T_RP[15:0];
                end
            end
            default: begin
                state_nxt = S_IDLE;
                cnt_nxt   = 16'h0000;
            end
        endcase
    end

    // State, counters and captured request.
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            state_r    <= S_PWRUP;
            cnt_r      <= PWRUP_CYC[15:0];
            init_cnt_r <= 4'h0;
            we_r       <= 1'b0;
            addr_r     <= 18'h00000;
            wdata_r    <= 9'h000;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            // Counts start-up refreshes and stops at eight, so idle is never left for init again.
            if (state_r == S_RFRAS && cnt_r == 16'h0000 &&
                init_cnt_r < `DMC_INIT_CYCLES) begin
                init_cnt_r <= init_cnt_r + 4'h1;
            end
            if (state_r == S_IDLE && o_ready && i_req) begin
                we_r    <= i_we;
                addr_r  <= i_addr;
                wdata_r <= i_wdata;
            end
        end
    end

    // Pin and user outputs, all registered.
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            o_addr                <= 9'h000;
            o_row_strobe_n        <= 1'b1;
            o_col_strobe_n        <= 1'b1;
            o_parity_col_strobe_n <= 1'b1;
            o_write_enable_n      <= 1'b1;
            o_data_io             <= 8'h00;
            o_data_io_oe          <= 1'b0;
            o_parity_data_in      <= 1'b0;
            o_busy                <= 1'b1;
            o_ready               <= 1'b0;
            o_rvalid              <= 1'b0;
            o_rdata               <= 9'h000;
            o_present             <= 1'b0;
        end else begin
            o_present <= ~prd_sync;
            o_rvalid  <= 1'b0;
            o_busy    <= (state_nxt != S_IDLE);
            o_ready   <= (state_nxt == S_IDLE) && !ref_due_r && !ref_set;
            case (state_nxt)
                S_ROW: begin
                    // Row address first, then row strobe after address setup.
                    o_addr         <= (state_r == S_IDLE) ?
                                      i_addr[17:9] : addr_r[17:9];
                    o_row_strobe_n <= (state_r == S_IDLE) ? 1'b1 : 1'b0;
                    o_write_enable_n <= ~we_r;
                    o_data_io        <= wdata_r[7:0];
                    o_parity_data_in <= wdata_r[8];
                    o_data_io_oe     <= we_r;
                end
                S_COL: begin
                    o_addr <= addr_r[8:0];
                end
                S_CASLO: begin
                    // On a write, write enable was already low, so the module stays off the bus.
                    o_col_strobe_n        <= 1'b0;
                    o_parity_col_strobe_n <= 1'b0;
                end
                S_PRE: begin
                    if (state_r == S_CASLO && !we_r) begin
                        o_rvalid <= 1'b1;
                        o_rdata  <= {rd_sync[8], rd_sync[7:0]};
                    end
                    o_row_strobe_n        <= 1'b1;
                    o_col_strobe_n        <= 1'b1;
                    o_parity_col_strobe_n <= 1'b1;
                    o_write_enable_n      <= 1'b1;
                    o_data_io_oe          <= 1'b0;
                end
                S_RFCAS: begin
                    // Column strobes lead the row strobe; pins need no address.
                    o_col_strobe_n        <= 1'b0;
                    o_parity_col_strobe_n <= 1'b0;
                    o_row_strobe_n        <= 1'b1;
                    o_write_enable_n      <= 1'b1;
                    o_data_io_oe          <= 1'b0;
                end
                S_RFRAS: begin
                    o_row_strobe_n <= 1'b0;
                end
                S_RFPRE: begin
                    o_row_strobe_n        <= 1'b1;
                    o_col_strobe_n        <= 1'b1;
                    o_parity_col_strobe_n <= 1'b1;
                end
                default: begin
                    o_row_strobe_n        <= 1'b1;
                    o_col_strobe_n        <= 1'b1;
                    o_parity_col_strobe_n <= 1'b1;
                    o_write_enable_n      <= 1'b1;
                    o_data_io_oe          <= 1'b0;
                end
            endcase
        end
    end
endmodule

// [verilog/dmc_defines.vh]
// Constants for the 9-bit DRAM module controller.
`ifndef DMC_DEFINES_VH
`define DMC_DEFINES_VH
`define DMC_CLK_NS        4
`define DMC_ADDR_W        18
`define DMC_PIN_ADDR_W    9
`define DMC_ROW_LSB       9
`define DMC_COL_LSB       0
`define DMC_REFRESH_ROWS  256
`define DMC_REF_PERIOD_US 4000
`define DMC_REF_EVERY_NS  15000
`define DMC_REF_EVERY_CYC ((`DMC_REF_EVERY_NS) / (`DMC_CLK_NS))
`define DMC_PWRUP_US      200
`define DMC_PWRUP_CYC     ((`DMC_PWRUP_US * 1000) / (`DMC_CLK_NS))
`define DMC_INIT_CYCLES   8
`define DMC_TRP_NS        120
`define DMC_TRP_CYC       ((`DMC_TRP_NS + `DMC_CLK_NS - 1) / (`DMC_CLK_NS))
`define DMC_TRAS_NS       200
`define DMC_TRAS_CYC      ((`DMC_TRAS_NS + `DMC_CLK_NS - 1) / (`DMC_CLK_NS))
`define DMC_TRCD_NS       30
`define DMC_TRCD_CYC      ((`DMC_TRCD_NS + `DMC_CLK_NS - 1) / (`DMC_CLK_NS))
`define DMC_TCAS_NS       100
`define DMC_TCAS_CYC      ((`DMC_TCAS_NS + `DMC_CLK_NS - 1) / (`DMC_CLK_NS))
`define DMC_TCSR_NS       35
`define DMC_TCSR_CYC      ((`DMC_TCSR_NS + `DMC_CLK_NS - 1) / (`DMC_CLK_NS))
`define DMC_TRSH_NS       100
`define DMC_TRSH_CYC      ((`DMC_TRSH_NS + `DMC_CLK_NS - 1) / (`DMC_CLK_NS))
`define DMC_TSYNC_CYC     2
`define DMC_CNT_W         16
`endif

// [verilog/dmc_sync.v]
// Two-flop synchroniser for pins coming from the module.
`timescale 1ns/1ps
module dmc_sync #(
    parameter W = 1
) (
    // Clock and reset.
    input  wire         i_clk,
    input  wire         i_nrst,
    // Asynchronous input and synchronised output.
    input  wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    // The first stage feeds only the second stage.
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;
endmodule

// [test/dmc_dram_model.sv]
// Behavioural model of the nine-bit DRAM module seen at the controller pins.
`timescale 1ns/1ps
module dmc_dram_model #(
    parameter T_ACC_NS = 60
) (
    // Strobes and address from the controller.
    input  wire       row_strobe_n,
    input  wire       col_strobe_n,
    input  wire       parity_col_strobe_n,
    input  wire       write_enable_n,
    input  wire [8:0] addr,
    // Data pins.
    input  wire [7:0] dq_in,
    input  wire       dq_in_oe,
    input  wire       d9,
    output wire [7:0] dq_out,
    output wire       q9,
    output wire       presence_detect_n
);
    logic [7:0] mem8 [logic [17:0]];
    logic       mem9 [logic [17:0]];
    logic [8:0] row_r;
    logic [7:0] ref_cnt_r = 8'h00;
    logic [7:0] rdat8_r = 8'h00;
    logic       rdat9_r = 1'b0;
    logic       rd8_r = 1'b0;
    logic       rd9_r = 1'b0;
    // The pin is tied to ground on the module; the host side supplies the pull-up.
    assign presence_detect_n = 1'b0;
    // Released pins show the inverse of the last read, never a kind constant.
    assign dq_out = rd8_r ? rdat8_r : ~rdat8_r;
    assign q9     = rd9_r ? rdat9_r : ~rdat9_r;
    // Row strobe fall latches the row, or refreshes from the counter when a column strobe leads.
    always @(negedge row_strobe_n) begin
        if (!col_strobe_n) ref_cnt_r <= ref_cnt_r + 8'h01;
        else row_r <= addr;
    end
    // Main column strobe serves bits seven to zero; undriven write data is stored corrupted.
    always @(negedge col_strobe_n) if (!row_strobe_n) begin
        if (!write_enable_n) begin
            mem8[{row_r, addr}] = dq_in_oe ? dq_in : ~dq_in;
        end else begin
            rdat8_r = mem8.exists({row_r, addr}) ? mem8[{row_r, addr}] : 8'h00;
            rd8_r <= #T_ACC_NS 1'b1;
        end
    end
    // Parity column strobe works the ninth bit on its own.
    always @(negedge parity_col_strobe_n) if (!row_strobe_n) begin
        if (!write_enable_n) mem9[{row_r, addr}] = d9;
        else begin
            rdat9_r = mem9.exists({row_r, addr}) ? mem9[{row_r, addr}] : 1'b0;
            rd9_r <= #T_ACC_NS 1'b1;
        end
    end
    // Outputs float again as soon as each column strobe rises.
    always @(posedge col_strobe_n) rd8_r <= 1'b0;
    always @(posedge parity_col_strobe_n) rd9_r <= 1'b0;
    // Write enable falling under a low column strobe is a late write: driven levels go invalid.
    always @(negedge write_enable_n) if (!col_strobe_n) rdat8_r = ~rdat8_r;
endmodule

// [test/dmc_ctrl_assertions.sv]
// Pin-level timing checks for the DRAM controller.
`timescale 1ns/1ps
module dmc_ctrl_assertions (
    // Clock, reset and presence input.
    input logic       i_clk,
    input logic       i_nrst,
    input logic       i_presence_detect_n,
    // Controller outputs.
    input logic [8:0] o_addr,
    input logic       o_row_strobe_n,
    input logic       o_col_strobe_n,
    input logic       o_parity_col_strobe_n,
    input logic       o_write_enable_n,
    input logic       o_data_io_oe,
    input logic       o_rvalid,
    input logic       o_ready,
    input logic       o_busy,
    input logic       o_present
);
    logic [3:0] init_cnt_r;
    // Counts initial row strobes; it saturates so a long run cannot wrap it back below eight.
    always @(posedge i_clk) begin
        if (!i_nrst) init_cnt_r <= 4'h0;
        else if ($fell(o_row_strobe_n) && init_cnt_r != 4'h8) init_cnt_r <= init_cnt_r + 4'h1;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    a_reset_pins_idle: assert property (disable iff (1'b0)
        !i_nrst |=> o_row_strobe_n && o_col_strobe_n && !o_data_io_oe && !o_ready && !o_rvalid)
        else $error("pins not idle in reset");
    a_strobes_paired: assert property (o_col_strobe_n == o_parity_col_strobe_n)
        else $error("column strobes differ");
    a_row_addr_stable: assert property (
        $fell(o_row_strobe_n) && o_col_strobe_n |-> $stable(o_addr)) else $error("row addr moved");
    a_col_addr_stable: assert property (
        $fell(o_col_strobe_n) && !o_row_strobe_n |-> $stable(o_addr)) else $error("col addr moved");
    a_early_write_set: assert property (
        $fell(o_col_strobe_n) && !o_row_strobe_n |-> $stable(o_write_enable_n))
        else $error("write enable moved at column strobe");
    a_drive_only_write: assert property (o_data_io_oe |-> !o_write_enable_n)
        else $error("data driven outside write");
    a_cbr_lead_time: assert property (
        $fell(o_col_strobe_n) && o_row_strobe_n |-> o_row_strobe_n [*8])
        else $error("refresh column lead too short");
    a_rvalid_single: assert property (o_rvalid |=> !o_rvalid)
        else $error("rvalid longer than one cycle");
    a_init_before_use: assert property (o_ready |-> init_cnt_r == 4'h8 && !o_busy)
        else $error("ready before eight init cycles");
    a_presence_sync: assert property (
        $changed(i_presence_detect_n) |-> ##3 (o_present != $past(i_presence_detect_n, 3)))
        else $error("presence not reflected");
endmodule
bind dmc_ctrl dmc_ctrl_assertions u_chk (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_presence_detect_n(i_presence_detect_n),
    .o_addr(o_addr), .o_row_strobe_n(o_row_strobe_n), .o_col_strobe_n(o_col_strobe_n),
    .o_parity_col_strobe_n(o_parity_col_strobe_n), .o_write_enable_n(o_write_enable_n),
    .o_data_io_oe(o_data_io_oe), .o_rvalid(o_rvalid), .o_ready(o_ready), .o_busy(o_busy),
    .o_present(o_present));

// [test/dram_module_9bit_access_tb_top.sv]
// Self-checking bench: writes, reads back and presence sensing through the module model.
`timescale 1ns/1ps
module dram_module_9bit_access_tb_top;
    logic        i_clk = 1'b0;
    logic        i_nrst = 1'b0;
    logic        i_req = 1'b0;
    logic        i_we = 1'b0;
    logic [17:0] i_addr = 18'h00000;
    logic [8:0]  i_wdata = 9'h000;
    logic        slot_empty = 1'b0;
    wire         o_busy, o_rvalid, o_ready, o_present, o_row_strobe_n, o_col_strobe_n;
    wire         o_parity_col_strobe_n, o_write_enable_n, o_data_io_oe, o_parity_data_in;
    wire         i_parity_data_out, model_pd_n, i_presence_detect_n;
    wire [8:0]   o_rdata, o_addr;
    wire [7:0]   i_data_io, o_data_io;
    int          fails = 0;
    int          n_tests = 0;
    int          cyc = 0;
    logic [8:0]  exp_q [$];
    logic [17:0] adr [10];
    logic [8:0]  dat [10];
    // Pull-up on the presence line when no module sits in the slot.
    assign i_presence_detect_n = slot_empty ? 1'b1 : model_pd_n;
    always #2 i_clk = ~i_clk;
    dmc_ctrl #(.PWRUP_CYC(20), .REF_CYC(200)) dut (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_req(i_req), .i_we(i_we), .i_addr(i_addr),
        .i_wdata(i_wdata), .o_busy(o_busy), .o_rvalid(o_rvalid), .o_rdata(o_rdata),
        .o_ready(o_ready), .o_present(o_present), .o_addr(o_addr),
        .o_row_strobe_n(o_row_strobe_n), .o_col_strobe_n(o_col_strobe_n),
        .o_parity_col_strobe_n(o_parity_col_strobe_n), .o_write_enable_n(o_write_enable_n),
        .i_data_io(i_data_io), .o_data_io(o_data_io), .o_data_io_oe(o_data_io_oe),
        .o_parity_data_in(o_parity_data_in), .i_parity_data_out(i_parity_data_out),
        .i_presence_detect_n(i_presence_detect_n));
    dmc_dram_model u_mod (
        .row_strobe_n(o_row_strobe_n), .col_strobe_n(o_col_strobe_n),
        .parity_col_strobe_n(o_parity_col_strobe_n), .write_enable_n(o_write_enable_n),
        .addr(o_addr), .dq_in(o_data_io), .dq_in_oe(o_data_io_oe), .d9(o_parity_data_in),
        .dq_out(i_data_io), .q9(i_parity_data_out), .presence_detect_n(model_pd_n));
    // Prints the verdict and ends the run.
    task automatic wrap_up();
        if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One access; the request is only raised once ready is seen, and held one full cycle.
    task automatic access(input logic we, input logic [17:0] a,
                          input logic [8:0] d, input logic [8:0] e);
        while (o_ready !== 1'b1) @(negedge i_clk);
        i_req = 1'b1;
        i_we = we;
        i_addr = a;
        i_wdata = d;
        if (!we) exp_q.push_back(e);
        @(negedge i_clk);
        i_req = 1'b0;
    endtask
    // Each read result is matched against the oldest note; a result with no note is an error.
    always @(negedge i_clk) if (o_rvalid === 1'b1) begin
        if (exp_q.size() != 0) check("rdata", o_rdata, exp_q.pop_front());
        else check("unexpected rvalid", 9'h001, 9'h000);
    end
    // A hang is cut short well past the expected run length.
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(32'hD366));
        repeat (8) @(negedge i_clk);
        i_nrst = 1'b1;
        // Corner addresses first, then random ones; all written back to back.
        for (int i = 0; i < 10; i++) begin
            // Low bits carry the index so random addresses never alias each other or the corners.
            adr[i] = (i == 0) ? 18'h00000 : (i == 1) ? 18'h3FFFF : {14'($urandom), 4'(i)};
            dat[i] = 9'($urandom);
            access(1'b1, adr[i], dat[i], 9'h000);
        end
        // Reverse order read-back, spanning several refresh preemptions.
        for (int i = 9; i >= 0; i--) access(1'b0, adr[i], 9'h000, dat[i]);
        access(1'b1, adr[0], ~dat[0], 9'h000);
        access(1'b0, adr[0], 9'h000, ~dat[0]);
        slot_empty = 1'b1;
        repeat (6) @(negedge i_clk);
        check("present empty", {8'h00, o_present}, 9'h000);
        slot_empty = 1'b0;
        repeat (6) @(negedge i_clk);
        check("present fitted", {8'h00, o_present}, 9'h001);
        while (exp_q.size() != 0) @(negedge i_clk);
        wrap_up();
    end
endmodule
